// ---- core/srst_pkg.sv ----
// Package for the serial receive status tracker: register map, field layout, limits.
// Assumes a 32-bit Avalon-MM slave with word-index addressing.
package srst_pkg;
  localparam int NUM_PORTS = 3;
  localparam int MAX_BYTES = 256;
  localparam int CNT_W = 9;
  localparam int ADDR_W = 4;
  localparam int DATA_W = 32;

  // Register word indices
  localparam logic [3:0] REG_STATUS_MAIN = 4'h0;
  localparam logic [3:0] REG_CNT_FIRST = 4'h1;
  localparam logic [3:0] REG_CNT_SECOND = 4'h2;
  localparam logic [3:0] REG_STATUS_EXP = 4'h3;
  localparam logic [3:0] REG_CNT_EXP = 4'h4;
  localparam logic [3:0] REG_CFG_FIRST = 4'h5;
  localparam logic [3:0] REG_CFG_SECOND = 4'h6;
  localparam logic [3:0] REG_CFG_EXP = 4'h7;
  localparam logic [3:0] REG_CMD = 4'h8;
  localparam logic [3:0] REG_RESTART = 4'h9;

  // Status bit positions
  localparam int BIT_DONE_FIRST = 6;
  localparam int BIT_OVF_FIRST = 7;
  localparam int BIT_DONE_SECOND = 14;
  localparam int BIT_OVF_SECOND = 15;
  localparam int BIT_DONE_EXP = 6;
  localparam int BIT_OVF_EXP = 7;

  // Configuration word layout
  localparam int CFG_COUNT_LSB = 0;
  localparam int CFG_CODE_LSB = 8;
  localparam int CFG_MODE_BIT = 16;

  // Command word layout: length in [8:0], port in [17:16]
  localparam int CMD_LEN_LSB = 0;
  localparam int CMD_LEN_W = 9;
  localparam int CMD_PORT_LSB = 16;
  localparam int RESTART_BIT = 0;

  localparam logic [7:0] CFG_COUNT_RESET = 8'h00;
  localparam logic [7:0] CFG_CODE_RESET = 8'h00;
  localparam logic CFG_MODE_RESET = 1'b0;

  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } srst_rx_s;

  typedef struct packed {
    logic end_mode;
    logic [7:0] end_code;
    logic [7:0] count;
  } srst_cfg_s;
endpackage : srst_pkg

// ---- core/srst_port.sv ----
// One receive port: completion flag, overflow flag and byte counter.
// Assumes one received byte per cycle of valid high, synchronous to clk_in.
`timescale 1ns/1ps
`default_nettype none
module srst_port #(
  parameter bit FIRST_PORT = 1'b0,
  parameter int MAX_BYTES = srst_pkg::MAX_BYTES
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire srst_pkg::srst_rx_s rx_in,
  input wire srst_pkg::srst_cfg_s cfg_in,
  input wire logic read_cmd_in,
  input wire logic zero_len_in,
  input wire logic restart_in,
  output logic done_out,
  output logic ovf_out,
  output logic code_seen_out,
  output logic [15:0] count_out
);
  logic [srst_pkg::CNT_W-1:0] count;
  logic [srst_pkg::CNT_W-1:0] target;
  logic [srst_pkg::CNT_W-1:0] base_cnt;
  logic [srst_pkg::CNT_W-1:0] next_count;
  logic clr;
  logic base_done;
  logic base_seen;
  logic next_done;
  logic next_seen;
  logic ovf_set;

  // Code 00 stands for a full 256-byte frame
  assign target = (cfg_in.count == 8'h00) ? srst_pkg::CNT_W'(MAX_BYTES)
                                           : {1'b0, cfg_in.count};
  assign clr = read_cmd_in | restart_in;
  assign base_done = clr ? 1'b0 : done_out;
  assign base_cnt = clr ? '0 : count;
  assign base_seen = clr ? 1'b0 : code_seen_out;

  // A byte landing with a clear starts the next frame rather than being lost
  always_comb
  begin
    next_done = base_done;
    next_count = base_cnt;
    next_seen = base_seen;
    ovf_set = 1'b0;
    if (rx_in.valid)
    begin
      if (base_done)
      begin
        if (!cfg_in.end_mode)
          ovf_set = 1'b1;
        else if (FIRST_PORT)
          ovf_set = 1'b1;
        else if (!base_seen)
          ovf_set = 1'b1;
      end
      else
      begin
        next_count = base_cnt + srst_pkg::CNT_W'(1);
        if (!cfg_in.end_mode)
        begin
          if (next_count == target)
            next_done = 1'b1;
        end
        else if (rx_in.data == cfg_in.end_code)
        begin
          next_done = 1'b1;
          next_seen = 1'b1;
        end
        else if (next_count == srst_pkg::CNT_W'(MAX_BYTES))
          next_done = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      done_out <= 1'b0;
      count <= '0;
      code_seen_out <= 1'b0;
    end
    else
    begin
      done_out <= next_done;
      count <= next_count;
      code_seen_out <= next_seen;
    end
  end

  // Overflow is only cleared by a zero-length read; a new overflow wins over it
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
      ovf_out <= 1'b0;
    else
      ovf_out <= (ovf_out & ~(read_cmd_in & zero_len_in)) | ovf_set;
  end

  assign count_out = {7'h00, count};
endmodule : srst_port
`default_nettype wire

// ---- core/srst_top.sv ----
// Serial receive status tracker: three ports of free-format reception status,
// reachable as registers over an Avalon-MM slave with waitrequest.
// Assumes byte strobes from the serial framers and word-index bus addresses.
//
// Register access over Avalon-MM and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module srst_top (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire srst_pkg::srst_rx_s [srst_pkg::NUM_PORTS-1:0] rx_in,
  input wire logic [srst_pkg::ADDR_W-1:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [srst_pkg::DATA_W-1:0] avs_writedata_in,
  output logic [srst_pkg::DATA_W-1:0] avs_readdata_out,
  output logic avs_waitrequest_out
);
  localparam int NP = srst_pkg::NUM_PORTS;

  logic ack;
  logic do_wr;
  logic [NP-1:0] done;
  logic [NP-1:0] ovf;
  logic [NP-1:0] seen;
  logic [NP-1:0] rd_cmd;
  logic [15:0] cnt [NP];
  srst_pkg::srst_cfg_s cfg [NP];
  logic zero_len;
  logic restart;
  logic [1:0] cmd_port;
  logic [srst_pkg::DATA_W-1:0] rd_mux;

  // One wait cycle per access; the request is taken on the edge ending it
  assign avs_waitrequest_out = (avs_read_in | avs_write_in) & ~ack;
  assign do_wr = avs_write_in & ack;

  always_ff @(posedge clk_in)
  begin
    if (rst_in)
      ack <= 1'b0;
    else
      ack <= (avs_read_in | avs_write_in) & ~ack;
  end

  assign cmd_port = avs_writedata_in[srst_pkg::CMD_PORT_LSB +: 2];
  assign zero_len = avs_writedata_in[srst_pkg::CMD_LEN_LSB +: srst_pkg::CMD_LEN_W]
                    == 9'h000;
  assign restart = do_wr && avs_address_in == srst_pkg::REG_RESTART
                   && avs_writedata_in[srst_pkg::RESTART_BIT];

  genvar g;
  generate
    for (g = 0; g < NP; g++)
    begin : g_port
      // Port index 3 in the command word selects nothing
      assign rd_cmd[g] = do_wr && avs_address_in == srst_pkg::REG_CMD
                         && cmd_port == 2'(g);

      always_ff @(posedge clk_in)
      begin
        if (rst_in)
        begin
          cfg[g].count <= srst_pkg::CFG_COUNT_RESET;
          cfg[g].end_code <= srst_pkg::CFG_CODE_RESET;
          cfg[g].end_mode <= srst_pkg::CFG_MODE_RESET;
        end
        else if (do_wr && avs_address_in == srst_pkg::REG_CFG_FIRST + 4'(g))
        begin
          cfg[g].count <= avs_writedata_in[srst_pkg::CFG_COUNT_LSB +: 8];
          cfg[g].end_code <= avs_writedata_in[srst_pkg::CFG_CODE_LSB +: 8];
          cfg[g].end_mode <= avs_writedata_in[srst_pkg::CFG_MODE_BIT];
        end
      end

      srst_port #(
        .FIRST_PORT(g == 0),
        .MAX_BYTES(srst_pkg::MAX_BYTES)
      ) u_port (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .rx_in(rx_in[g]),
        .cfg_in(cfg[g]),
        .read_cmd_in(rd_cmd[g]),
        .zero_len_in(zero_len),
        .restart_in((g == 0) ? restart : 1'b0),
        .done_out(done[g]),
        .ovf_out(ovf[g]),
        .code_seen_out(seen[g]),
        .count_out(cnt[g])
      );
    end
  endgenerate

  always_comb
  begin
    rd_mux = '0;
    unique case (avs_address_in)
      srst_pkg::REG_STATUS_MAIN:
      begin
        rd_mux[srst_pkg::BIT_DONE_FIRST] = done[0];
        rd_mux[srst_pkg::BIT_OVF_FIRST] = ovf[0];
        rd_mux[srst_pkg::BIT_DONE_SECOND] = done[1];
        rd_mux[srst_pkg::BIT_OVF_SECOND] = ovf[1];
      end
      srst_pkg::REG_CNT_FIRST: rd_mux[15:0] = cnt[0];
      srst_pkg::REG_CNT_SECOND: rd_mux[15:0] = cnt[1];
      srst_pkg::REG_STATUS_EXP:
      begin
        rd_mux[srst_pkg::BIT_DONE_EXP] = done[2];
        rd_mux[srst_pkg::BIT_OVF_EXP] = ovf[2];
      end
      srst_pkg::REG_CNT_EXP: rd_mux[15:0] = cnt[2];
      srst_pkg::REG_CFG_FIRST: rd_mux[16:0] = cfg[0];
      srst_pkg::REG_CFG_SECOND: rd_mux[16:0] = cfg[1];
      srst_pkg::REG_CFG_EXP: rd_mux[16:0] = cfg[2];
      default: rd_mux = '0;
    endcase
  end

  // Sampled in the wait cycle so it is stable when waitrequest drops
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
      avs_readdata_out <= '0;
    else if (avs_read_in && !ack)
      avs_readdata_out <= rd_mux;
  end

  // Watches the first port in byte-count frames with settings other than 00
  property p_r1;
    @(posedge clk_in) disable iff (rst_in)
      rx_in[0].valid && !cfg[0].end_mode && !done[0] && !rd_cmd[0] && !restart
      && cfg[0].count != 8'h00 && cnt[0] + 16'h0001 == {8'h00, cfg[0].count} |=> done[0];
  endproperty
  a_r1: assert property (p_r1) else $error("count frame did not complete");

  property p_r2;
    @(posedge clk_in) disable iff (rst_in)
      rx_in[2].valid && cfg[2].end_mode && !done[2] && !rd_cmd[2]
      && rx_in[2].data == cfg[2].end_code |=> done[2] && seen[2];
  endproperty
  a_r2: assert property (p_r2) else $error("end code did not complete frame");

  property p_r3;
    @(posedge clk_in) disable iff (rst_in)
      rx_in[1].valid && !cfg[1].end_mode && done[1] && !rd_cmd[1] |=> ovf[1] && done[1];
  endproperty
  a_r3: assert property (p_r3) else $error("byte after count frame not flagged");

  property p_r4;
    @(posedge clk_in) disable iff (rst_in)
      rx_in[2].valid && cfg[2].end_mode && done[2] && !seen[2] && !rd_cmd[2]
      ##1 !rd_cmd[2] |-> ovf[2] && cnt[2] == 16'h0100;
  endproperty
  a_r4: assert property (p_r4) else $error("257th byte not flagged");

  property p_r5;
    @(posedge clk_in) disable iff (rst_in)
      rx_in[0].valid && cfg[0].end_mode && done[0] && seen[0] && !rd_cmd[0] |=> ovf[0];
  endproperty
  a_r5: assert property (p_r5) else $error("byte after end code not flagged");

  property p_r6;
    @(posedge clk_in) disable iff (rst_in)
      cnt[0] <= 16'h0100 && cnt[1] <= 16'h0100 && cnt[2] <= 16'h0100;
  endproperty
  a_r6: assert property (p_r6) else $error("byte counter beyond range");

  property p_r7;
    @(posedge clk_in) disable iff (rst_in)
      avs_read_in && !ack && avs_address_in == srst_pkg::REG_STATUS_MAIN
      |=> avs_readdata_out[15:14] == $past({ovf[1], done[1]})
      && avs_readdata_out[7:6] == $past({ovf[0], done[0]});
  endproperty
  a_r7: assert property (p_r7) else $error("status word layout wrong");

  property p_r8;
    @(posedge clk_in) disable iff (rst_in)
      rd_cmd[1] && !rx_in[1].valid |=> !done[1] && cnt[1] == 16'h0000;
  endproperty
  a_r8: assert property (p_r8) else $error("receive read did not clear");

  // Watches the second port in full 256-byte frames, the setting that every port resets to
  property p_r9;
    @(posedge clk_in) disable iff (rst_in)
      rx_in[1].valid && !cfg[1].end_mode && cfg[1].count == 8'h00 && !done[1] && !rd_cmd[1]
      && cnt[1] == 16'h00FF |=> done[1] && cnt[1] == 16'h0100;
  endproperty
  a_r9: assert property (p_r9) else $error("code 00 did not mean 256");

  property p_r10;
    @(posedge clk_in) disable iff (rst_in)
      restart && !rx_in[0].valid |=> !done[0] && cnt[0] == 16'h0000 && ovf[0] == $past(ovf[0]);
  endproperty
  a_r10: assert property (p_r10) else $error("restart did not clear port");

  property p_r11;
    @(posedge clk_in) disable iff (rst_in)
      rd_cmd[2] && zero_len && !rx_in[2].valid |=> !ovf[2] && !done[2] && cnt[2] == 16'h0000;
  endproperty
  a_r11: assert property (p_r11) else $error("zero-length read left flags set");

  property p_r12;
    @(posedge clk_in) rst_in |=> done == 3'h0 && ovf == 3'h0 && cnt[0] == 16'h0000
      && cnt[1] == 16'h0000 && cnt[2] == 16'h0000;
  endproperty
  a_r12: assert property (p_r12) else $error("reset did not clear state");

  property p_cov_done;
    @(posedge clk_in) disable iff (rst_in) $rose(done[0]);
  endproperty
  c_cov_done: cover property (p_cov_done);

  property p_cov_ovf;
    @(posedge clk_in) disable iff (rst_in) $rose(ovf[2]);
  endproperty
  c_cov_ovf: cover property (p_cov_ovf);

  property p_cov_read;
    @(posedge clk_in) disable iff (rst_in) done[1] ##1 rd_cmd[1];
  endproperty
  c_cov_read: cover property (p_cov_read);

  property p_cov_restart;
    @(posedge clk_in) disable iff (rst_in) restart && done[0];
  endproperty
  c_cov_restart: cover property (p_cov_restart);
endmodule : srst_top
`default_nettype wire

// ---- testbench/srst_far_src.sv ----
// Far-side model: an external serial device handing received bytes to the three ports.
// Assumes the bench calls send right after a rising edge of clk_in.
`timescale 1ns/1ps
`default_nettype none
module srst_far_src (
  input wire logic clk_in,
  output var srst_pkg::srst_rx_s [srst_pkg::NUM_PORTS-1:0] rx_out
);
  initial rx_out = '0;

  // The strobe stays high across back-to-back bytes, so it is assigned once per edge.
  // When idle, the data lines show the inverse of the last byte so that stale data never
  // looks fresh.
  task automatic send(input int p, input logic [7:0] d, input bit last);
    rx_out[p] <= '{valid: 1'b1, data: d};
    @(posedge clk_in);
    if (last)
      rx_out[p] <= '{valid: 1'b0, data: ~d};
  endtask : send
endmodule : srst_far_src
`default_nettype wire

// ---- testbench/tb_srst_top.sv ----
// Testbench top for the serial receive status tracker: corner frames and random frames.
// Assumes the far-side model feeds the bytes and registers sit at the package word indices.
`timescale 1ns/1ps
`default_nettype none
module tb_srst_top;
  logic clk_in;
  logic rst_in;
  srst_pkg::srst_rx_s [srst_pkg::NUM_PORTS-1:0] rx;
  logic [3:0] addr;
  logic rd;
  logic wr;
  logic [31:0] wdata;
  logic [31:0] rdata;
  logic wait_req;
  logic [31:0] q;
  logic [7:0] code;
  int miscompares = 0;
  int n_tests = 0;
  int seed = 41269;
  int n;
  int p;
  bit e_done [3];
  bit e_ovf [3];
  bit e_seen [3];
  bit e_mode [3];
  int e_cnt [3];
  int e_tgt [3];
  logic [7:0] e_code [3];

  srst_top u_srst_top (.clk_in(clk_in), .rst_in(rst_in), .rx_in(rx), .avs_address_in(addr),
    .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wdata),
    .avs_readdata_out(rdata), .avs_waitrequest_out(wait_req));
  srst_far_src u_srst_far_src (.clk_in(clk_in), .rx_out(rx));

  initial
  begin
    clk_in = 1'b0;
    forever #20 clk_in = ~clk_in;
  end

  task automatic close_out();
    if (miscompares == 0 && n_tests > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : close_out

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      miscompares++;
      $display("BAD t=%0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // Holds the request until waitrequest is sampled low, then releases after that edge
  task automatic bus(input bit w, input logic [3:0] a, input logic [31:0] d);
    int k;
    k = 0;
    addr <= a;
    wr <= w;
    rd <= !w;
    wdata <= d;
    do
    begin
      @(posedge clk_in);
      k++;
    end
    while (wait_req !== 1'b0 && k < 16);
    q = rdata;
    wr <= 1'b0;
    rd <= 1'b0;
    if (wait_req !== 1'b0)
    begin
      miscompares++;
      close_out();
    end
    @(posedge clk_in);
  endtask : bus

  task automatic check_all();
    logic [31:0] m;
    logic [31:0] x;
    m = 32'h0;
    x = 32'h0;
    m[srst_pkg::BIT_DONE_FIRST] = e_done[0];
    m[srst_pkg::BIT_OVF_FIRST] = e_ovf[0];
    m[srst_pkg::BIT_DONE_SECOND] = e_done[1];
    m[srst_pkg::BIT_OVF_SECOND] = e_ovf[1];
    x[srst_pkg::BIT_DONE_EXP] = e_done[2];
    x[srst_pkg::BIT_OVF_EXP] = e_ovf[2];
    bus(1'b0, srst_pkg::REG_STATUS_MAIN, 32'h0);
    chk(q, m);
    bus(1'b0, srst_pkg::REG_CNT_FIRST, 32'h0);
    chk(q, 32'(e_cnt[0]));
    bus(1'b0, srst_pkg::REG_CNT_SECOND, 32'h0);
    chk(q, 32'(e_cnt[1]));
    bus(1'b0, srst_pkg::REG_STATUS_EXP, 32'h0);
    chk(q, x);
    bus(1'b0, srst_pkg::REG_CNT_EXP, 32'h0);
    chk(q, 32'(e_cnt[2]));
  endtask : check_all

  task automatic cfg(input int pt, input bit m, input logic [7:0] c, input logic [7:0] k);
    logic [31:0] w;
    w = {15'h0, m, c, k};
    e_mode[pt] = m;
    e_code[pt] = c;
    e_tgt[pt] = (k == 8'h00) ? 256 : int'(k);
    bus(1'b1, srst_pkg::REG_CFG_FIRST + 4'(pt), w);
    bus(1'b0, srst_pkg::REG_CFG_FIRST + 4'(pt), 32'h0);
    chk(q, w);
  endtask : cfg

  task automatic clr(input int pt, input int len);
    bus(1'b1, srst_pkg::REG_CMD, {14'h0, 2'(pt), 7'h0, 9'(len)});
    e_done[pt] = 1'b0;
    e_cnt[pt] = 0;
    e_seen[pt] = 1'b0;
    if (len == 0)
      e_ovf[pt] = 1'b0;
  endtask : clr

  // Expected flags follow the framing of each port; once done, bytes are no longer counted
  task automatic feed(input int pt, input logic [7:0] d, input bit last);
    if (e_done[pt])
    begin
      if (!e_mode[pt] || pt == 0 || !e_seen[pt])
        e_ovf[pt] = 1'b1;
    end
    else
    begin
      e_cnt[pt]++;
      e_seen[pt] = e_mode[pt] && d == e_code[pt];
      e_done[pt] = e_seen[pt] || e_cnt[pt] == (e_mode[pt] ? 256 : e_tgt[pt]);
    end
    u_srst_far_src.send(pt, d, last);
  endtask : feed

  // With fin low the strobe stays up so the next call can follow without a second assignment
  task automatic burst(input int pt, input int k, input bit fin = 1'b1);
    logic [7:0] d;
    for (int i = 0; i < k; i++)
    begin
      d = 8'($random(seed));
      if (e_mode[pt] && d == e_code[pt])
        d = ~d;
      feed(pt, d, fin && i == k - 1);
    end
  endtask : burst

  // Expected state after a reset: flags and counters clear, settings back to 256-byte frames
  task automatic model_reset();
    for (int i = 0; i < 3; i++)
    begin
      e_done[i] = 1'b0;
      e_ovf[i] = 1'b0;
      e_seen[i] = 1'b0;
      e_mode[i] = 1'b0;
      e_cnt[i] = 0;
      e_tgt[i] = 256;
      e_code[i] = 8'h00;
    end
  endtask : model_reset

  initial
  begin
    rst_in = 1'b1;
    addr = 4'h0;
    rd = 1'b0;
    wr = 1'b0;
    wdata = 32'h0;
    model_reset();
    repeat (8) @(posedge clk_in);
    rst_in <= 1'b0;
    @(posedge clk_in);
    check_all();
    bus(1'b0, 4'hA, 32'h0);
    chk(q, 32'h0);
    bus(1'b1, srst_pkg::REG_CNT_FIRST, 32'hFFFFFFFF);
    bus(1'b0, srst_pkg::REG_CNT_FIRST, 32'h0);
    chk(q, 32'h0);
    // Byte-count frame of random length on the first port, then overflow and both clears
    n = 1 + ($unsigned($random(seed)) % 16);
    cfg(0, 1'b0, 8'h00, 8'(n));
    burst(0, n - 1);
    check_all();
    burst(0, 1, 1'b0);
    burst(0, 1);
    check_all();
    clr(0, 5);
    check_all();
    clr(0, 0);
    check_all();
    // Setting 00 on the second port means a full 256-byte frame
    burst(1, 255);
    check_all();
    burst(1, 2);
    check_all();
    clr(1, 0);
    // End-code framing on the expansion port: 256-byte cap, then the 257th byte
    code = 8'($random(seed));
    cfg(2, 1'b1, code, 8'h00);
    burst(2, 256);
    check_all();
    burst(2, 1);
    check_all();
    clr(2, 0);
    burst(2, 3, 1'b0);
    feed(2, code, 1'b0);
    burst(2, 1);
    check_all();
    clr(2, 4);
    // First port sees any byte after the end code as overflow
    cfg(0, 1'b1, code, 8'h00);
    burst(0, 2, 1'b0);
    feed(0, code, 1'b0);
    feed(0, ~code, 1'b1);
    check_all();
    clr(0, 0);
    cfg(0, 1'b0, 8'h00, 8'h03);
    burst(0, 4);
    bus(1'b1, srst_pkg::REG_RESTART, 32'h1);
    e_done[0] = 1'b0;
    e_cnt[0] = 0;
    e_seen[0] = 1'b0;
    check_all();
    clr(0, 0);
    // Random frames on random ports
    repeat (6)
    begin
      p = $unsigned($random(seed)) % 3;
      clr(p, 0);
      cfg(p, 1'b0, 8'h00, 8'(1 + $unsigned($random(seed)) % 8));
      burst(p, 1 + $unsigned($random(seed)) % 10);
      check_all();
      clr(p, $unsigned($random(seed)) % 3);
      check_all();
    end
    // Reset in mid-run must clear counted bytes and return the second port's setting to its idle value
    burst(1, 3);
    rst_in <= 1'b1;
    repeat (2) @(posedge clk_in);
    rst_in <= 1'b0;
    model_reset();
    @(posedge clk_in);
    check_all();
    bus(1'b0, srst_pkg::REG_CFG_SECOND, 32'h0);
    chk(q, 32'h0);
    close_out();
  end
endmodule : tb_srst_top
`default_nettype wire
